// [design/uft_pkg.sv]
// Purpose: Shared constants for the frame timer and root hub descriptor block
// Assumes: 32-bit register port, byte offsets as printed
// Notes: Port count setting values 2..5 are the only legal ones
package uft_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_FRAME_INTERVAL = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_FRAME_TIME_LEFT = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_FRAME_COUNT = 8'h3c;
	localparam logic [ADDR_W-1:0] OFS_PERIODIC_BEGIN = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_SLOW_CUTOFF = 8'h44;
	localparam logic [ADDR_W-1:0] OFS_HUB_DESC_FIRST = 8'h48;
	localparam logic [ADDR_W-1:0] OFS_HUB_DESC_SECOND = 8'h4c;
	localparam int unsigned TIME_W = 14;
	localparam int unsigned COUNT_W = 16;
	localparam int unsigned SLOW_W = 12;
	localparam logic [TIME_W-1:0] RST_INTERVAL = 14'h2edf;
	localparam logic [TIME_W-1:0] RST_PERIODIC = 14'h0000;
	localparam logic [SLOW_W-1:0] RST_SLOW = 12'h628;
	localparam logic [7:0] RST_POWER_GOOD = 8'h0f;
	localparam int unsigned TOGGLE_BIT = 31;
	localparam int unsigned PSM_BIT = 8;
	localparam int unsigned NPS_BIT = 9;
	localparam int unsigned DT_BIT = 10;
	localparam int unsigned OVERCURRENT_PER_PORT_BIT = 11;
	localparam int unsigned OVERCURRENT_UNSUPPORTED_BIT = 12;
	localparam int unsigned PGD_LSB = 24;
	localparam int unsigned MASK_LSB = 16;
	localparam logic [3:0] FIELD4_USED = 4'he;
	localparam logic [3:0] RST_REMOVABLE = 4'h0;
endpackage

// [design/uft_port_defaults.sv]
// Purpose: Port count and power mask defaults from the port count setting
// Assumes: Setting is static while the block runs
// Notes: Illegal settings fall back to the smallest configuration
`timescale 1ns/100ps
`default_nettype none
module uft_port_defaults (
	input wire logic [2:0] port_setting,
	input wire logic second_instance,
	output logic [7:0] port_count,
	output logic [3:0] mask_default
);
	import uft_pkg::*;
	always_comb begin
		port_count = 8'h01;
		mask_default = 4'h2;
		unique case (port_setting)
			3'h5: begin
				port_count = second_instance ? 8'h02 : 8'h03;
				mask_default = second_instance ? 4'h6 : 4'he;
			end
			3'h4: begin
				port_count = 8'h02;
				mask_default = 4'h6;
			end
			3'h3: begin
				port_count = second_instance ? 8'h01 : 8'h02;
				mask_default = second_instance ? 4'h2 : 4'h6;
			end
			3'h2: begin
				port_count = 8'h01;
				// One port only, so only its mask bit is set on either instance
				mask_default = 4'h2;
			end
			default: begin
				port_count = 8'h01;
				mask_default = 4'h2;
			end
		endcase
	end
endmodule
`default_nettype wire

// [design/uft_frame_timer.sv]
// Purpose: Frame timer, frame number and root hub descriptor registers
// Assumes: Register port strobes one cycle long; pins synchronous to mclk
// Notes: Descriptor fields ignore soft_reset; timer fields obey both resets
// Summary of operation
// - Fourteen-bit down counter of bit times left, read-only, resets to 2edf.
// - At zero, interval toggle is copied into bit 31 of time left.
// - Frame interval is fourteen bits, resets to 2edf, bit times per frame.
// - Interval toggle inverts whenever software loads a new frame interval.
// - Sixteen-bit frame count, resets zero, read-only, increments on each reload.
// - Fourteen-bit writable periodic begin value, reset zero.
// - Twelve-bit writable slow packet threshold, reset 628, gates low-speed starts.
// - Port count reported in read-only eight-bit field.
// - Port count derived from port setting and instance number.
// - Power switch select: 0 ganged, 1 per port, reset 1.
// - Always powered bit: 0 switchable, 1 always on, reset 0.
// - Compound flag always reads zero.
// - Overcurrent per port bit: 0 together, 1 per port, reset 1.
// - Overcurrent unsupported bit: 0 reported, 1 unsupported, reset 0.
// - Descriptor fields reset only on hardware reset, not software reset.
// - Four-bit removable field, bits for ports 1 to 3, bit 0 reserved.
// - Four-bit port power mask, bits for ports 1 to 3, bit 0 reserved.
// - Mask default follows port setting and instance; removable resets zero.
// - Reserved bits are read-only and read zero.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module uft_frame_timer #(
	parameter bit SECOND_INSTANCE = 1'b0
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic bit_time_tick,
	input wire logic [2:0] port_setting,
	input wire logic [uft_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [uft_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [uft_pkg::DATA_W-1:0] reg_rdata,
	output logic frame_start,
	output logic periodic_begin,
	output logic slow_packet_ok,
	output logic [uft_pkg::TIME_W-1:0] time_left_counter,
	output logic [uft_pkg::COUNT_W-1:0] frame_count_value
);
	import uft_pkg::*;

	// Elaboration checks: the read mux packs fields by these positions
	if (DATA_W != 32) begin : g_bad_data_w
		$error("Register data must be 32 bits wide");
	end
	if (TIME_W - SLOW_W != 2) begin : g_bad_slow_w
		$error("Slow threshold compare assumes a field two bits narrower");
	end
	if (TOGGLE_BIT <= TIME_W || TOGGLE_BIT >= DATA_W) begin : g_bad_toggle
		$error("Toggle bit must sit above the counter field");
	end

	logic [TIME_W-1:0] frame_interval_value_r;
	logic interval_toggle_r;
	logic [TIME_W-1:0] time_left_r;
	logic time_left_toggle_r;
	logic [COUNT_W-1:0] frame_count_r;
	logic [TIME_W-1:0] periodic_begin_value_r;
	logic [SLOW_W-1:0] slow_packet_threshold_r;
	logic power_switch_select_r;
	logic always_powered_r;
	logic overcurrent_per_port_r;
	logic overcurrent_unsupported_r;
	logic [7:0] power_good_delay_r;
	logic [3:0] removable_bits_r;
	logic [3:0] port_power_mask_r;
	logic periodic_begin_r;
	logic frame_start_r;
	logic [DATA_W-1:0] rdata_r;
	logic [7:0] port_count;
	logic [3:0] mask_default;
	logic reload;
	logic hub_init_r;
	logic timer_clr;

	uft_port_defaults u_defaults (
		.port_setting(port_setting),
		.second_instance(SECOND_INSTANCE),
		.port_count(port_count),
		.mask_default(mask_default)
	);

	function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
		return reg_write && (reg_addr == ofs);
	endfunction

	assign timer_clr = reset || soft_reset;
	assign reload = bit_time_tick && (time_left_r == '0);

	// Frame interval and its toggle
	always_ff @(posedge mclk) begin
		if (timer_clr) begin
			frame_interval_value_r <= RST_INTERVAL;
			interval_toggle_r <= 1'b0;
		end else if (wr_hit(OFS_FRAME_INTERVAL)) begin
			frame_interval_value_r <= reg_wdata[TIME_W-1:0];
			// Flip on each load so software can tell the new interval has taken effect
			interval_toggle_r <= ~interval_toggle_r;
		end
	end

	// Bit time down counter
	always_ff @(posedge mclk) begin
		if (timer_clr) begin
			time_left_r <= RST_INTERVAL;
			time_left_toggle_r <= 1'b0;
			frame_count_r <= '0;
			frame_start_r <= 1'b0;
		end else begin
			frame_start_r <= reload;
			if (reload) begin
				time_left_r <= frame_interval_value_r;
				time_left_toggle_r <= interval_toggle_r;
				frame_count_r <= frame_count_r + 16'h0001;
			end else if (bit_time_tick) begin
				time_left_r <= time_left_r - 14'h0001;
			end
		end
	end

	// Periodic window opens at the begin point and closes with the frame
	always_ff @(posedge mclk) begin
		if (timer_clr) begin
			periodic_begin_r <= 1'b0;
		end else if (reload) begin
			periodic_begin_r <= 1'b0;
		end else if (time_left_r <= periodic_begin_value_r) begin
			periodic_begin_r <= 1'b1;
		end
	end

	// Timing thresholds
	always_ff @(posedge mclk) begin
		if (timer_clr) begin
			periodic_begin_value_r <= RST_PERIODIC;
			slow_packet_threshold_r <= RST_SLOW;
		end else begin
			if (wr_hit(OFS_PERIODIC_BEGIN)) begin
				periodic_begin_value_r <= reg_wdata[TIME_W-1:0];
			end
			if (wr_hit(OFS_SLOW_CUTOFF)) begin
				slow_packet_threshold_r <= reg_wdata[SLOW_W-1:0];
			end
		end
	end

	// Descriptor fields: hardware reset only; the mask default is taken one
	// cycle after release so the strap is caught by a clocked load
	always_ff @(posedge mclk) begin
		if (reset) begin
			hub_init_r <= 1'b1;
			power_switch_select_r <= 1'b1;
			always_powered_r <= 1'b0;
			overcurrent_per_port_r <= 1'b1;
			overcurrent_unsupported_r <= 1'b0;
			power_good_delay_r <= RST_POWER_GOOD;
			removable_bits_r <= RST_REMOVABLE;
			port_power_mask_r <= 4'h0;
		end else begin
			hub_init_r <= 1'b0;
			if (hub_init_r) begin
				port_power_mask_r <= mask_default;
			end else if (wr_hit(OFS_HUB_DESC_SECOND)) begin
				port_power_mask_r <= reg_wdata[MASK_LSB +: 4] & FIELD4_USED;
			end
			if (wr_hit(OFS_HUB_DESC_SECOND)) begin
				removable_bits_r <= reg_wdata[3:0] & FIELD4_USED;
			end
			if (wr_hit(OFS_HUB_DESC_FIRST)) begin
				power_switch_select_r <= reg_wdata[PSM_BIT];
				always_powered_r <= reg_wdata[NPS_BIT];
				overcurrent_per_port_r <= reg_wdata[OVERCURRENT_PER_PORT_BIT];
				overcurrent_unsupported_r <= reg_wdata[OVERCURRENT_UNSUPPORTED_BIT];
				power_good_delay_r <= reg_wdata[PGD_LSB +: 8];
			end
		end
	end

	// Read data, valid in the cycle after the strobe only
	always_ff @(posedge mclk) begin
		if (reset || !reg_read) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= '0;
			unique case (reg_addr)
				OFS_FRAME_TIME_LEFT: begin
					rdata_r[TIME_W-1:0] <= time_left_r;
					rdata_r[TOGGLE_BIT] <= time_left_toggle_r;
				end
				OFS_FRAME_COUNT: rdata_r[COUNT_W-1:0] <= frame_count_r;
				OFS_PERIODIC_BEGIN: rdata_r[TIME_W-1:0] <= periodic_begin_value_r;
				OFS_SLOW_CUTOFF: rdata_r[SLOW_W-1:0] <= slow_packet_threshold_r;
				OFS_HUB_DESC_FIRST: begin
					rdata_r[7:0] <= port_count;
					rdata_r[PSM_BIT] <= power_switch_select_r;
					rdata_r[NPS_BIT] <= always_powered_r;
					rdata_r[DT_BIT] <= 1'b0;
					rdata_r[OVERCURRENT_PER_PORT_BIT] <= overcurrent_per_port_r;
					rdata_r[OVERCURRENT_UNSUPPORTED_BIT] <= overcurrent_unsupported_r;
					rdata_r[PGD_LSB +: 8] <= power_good_delay_r;
				end
				OFS_HUB_DESC_SECOND: begin
					rdata_r[3:0] <= removable_bits_r;
					rdata_r[MASK_LSB +: 4] <= port_power_mask_r;
				end
				default: rdata_r <= '0;
			endcase
		end
	end

	assign reg_rdata = rdata_r;
	assign frame_start = frame_start_r;
	assign periodic_begin = periodic_begin_r;
	// Low-speed start allowed only while more bit times remain than the threshold
	assign slow_packet_ok = ({2'b00, slow_packet_threshold_r} < time_left_r);
	assign time_left_counter = time_left_r;
	assign frame_count_value = frame_count_r;

	// Timer checks. Each antecedent also samples the clear, so an attempt that
	// starts on the edge applying a reset is never judged against the old state.
	a_reload_value: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && reload) |=> (time_left_r == $past(frame_interval_value_r)))
		else $error("Counter did not reload the interval");

	a_toggle_copy: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && reload) |=> (time_left_toggle_r == $past(interval_toggle_r)))
		else $error("Toggle not copied at reload");

	a_toggle_hold: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && !reload) |=> $stable(time_left_toggle_r))
		else $error("Remaining toggle moved without reload");

	a_count_step: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && reload) |=> (frame_count_r == $past(frame_count_r) + 16'h0001))
		else $error("Frame count did not step");

	a_count_hold: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && !reload) |=> $stable(frame_count_r))
		else $error("Frame count moved without reload");

	a_down_count: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && bit_time_tick && !reload) |=>
		(time_left_r == $past(time_left_r) - 14'h0001))
		else $error("Counter did not count down");

	a_time_hold: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && !bit_time_tick) |=> $stable(time_left_r))
		else $error("Counter moved without a bit time");

	a_frame_pulse: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && reload) |=> frame_start_r)
		else $error("No frame start after reload");

	a_frame_quiet: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && !reload) |=> !frame_start_r)
		else $error("Frame start without reload");

	a_interval_load: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && wr_hit(OFS_FRAME_INTERVAL)) |=>
		(frame_interval_value_r == $past(reg_wdata[TIME_W-1:0])))
		else $error("Frame interval not loaded");

	a_interval_toggle: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && wr_hit(OFS_FRAME_INTERVAL)) |=>
		(interval_toggle_r != $past(interval_toggle_r)))
		else $error("Interval toggle did not invert");

	a_toggle_still: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && !wr_hit(OFS_FRAME_INTERVAL)) |=> $stable(interval_toggle_r))
		else $error("Interval toggle moved without a load");

	a_timer_clear: assert property (@(posedge mclk)
		timer_clr |=> (time_left_r == RST_INTERVAL && frame_count_r == '0
		&& !time_left_toggle_r && !interval_toggle_r))
		else $error("Timer not cleared by reset");

	a_threshold_clear: assert property (@(posedge mclk)
		timer_clr |=> (periodic_begin_value_r == RST_PERIODIC
		&& slow_packet_threshold_r == RST_SLOW && frame_interval_value_r == RST_INTERVAL))
		else $error("Thresholds not cleared by reset");

	// Periodic window
	a_periodic_open: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && !reload && time_left_r <= periodic_begin_value_r) |=> periodic_begin_r)
		else $error("Periodic window did not open");

	a_window_close: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && reload) |=> !periodic_begin_r)
		else $error("Periodic window not closed at reload");

	a_window_hold: assert property (@(posedge mclk) disable iff (timer_clr)
		(!timer_clr && periodic_begin_r && !reload) |=> periodic_begin_r)
		else $error("Periodic window closed early");

	// Descriptor checks
	a_desc_reset: assert property (@(posedge mclk)
		reset |=> (power_switch_select_r && !always_powered_r && overcurrent_per_port_r
		&& !overcurrent_unsupported_r && power_good_delay_r == RST_POWER_GOOD
		&& removable_bits_r == RST_REMOVABLE))
		else $error("Descriptor fields not at reset values");

	a_mask_load: assert property (@(posedge mclk) disable iff (reset)
		(!reset && hub_init_r) |=> (port_power_mask_r == $past(mask_default)))
		else $error("Power mask default not loaded");

	a_desc_load: assert property (@(posedge mclk) disable iff (reset)
		(!reset && wr_hit(OFS_HUB_DESC_FIRST)) |=>
		(power_switch_select_r == $past(reg_wdata[PSM_BIT])
		&& overcurrent_per_port_r == $past(reg_wdata[OVERCURRENT_PER_PORT_BIT])
		&& power_good_delay_r == $past(reg_wdata[PGD_LSB +: 8])))
		else $error("Descriptor write not taken");

	a_desc_keep: assert property (@(posedge mclk) disable iff (reset)
		(!reset && soft_reset && !reg_write && !hub_init_r) |=>
		($stable(power_good_delay_r) && $stable(port_power_mask_r)))
		else $error("Descriptor changed on soft reset");

	a_mask_reserved: assert property (@(posedge mclk) disable iff (reset)
		!port_power_mask_r[0] && !removable_bits_r[0])
		else $error("Reserved descriptor bit set");

	// Read port
	a_rdata_idle: assert property (@(posedge mclk) disable iff (reset)
		(!reset && !reg_read) |=> (reg_rdata == '0))
		else $error("Read data not zero outside a read");

	a_time_left_read: assert property (@(posedge mclk) disable iff (reset)
		(!reset && reg_read && reg_addr == OFS_FRAME_TIME_LEFT) |=>
		(reg_rdata[TIME_W-1:0] == $past(time_left_r)
		&& reg_rdata[TOGGLE_BIT-1:TIME_W] == '0
		&& reg_rdata[TOGGLE_BIT] == $past(time_left_toggle_r)))
		else $error("Time left read wrong");

	a_count_read: assert property (@(posedge mclk) disable iff (reset)
		(!reset && reg_read && reg_addr == OFS_FRAME_COUNT) |=>
		(reg_rdata[COUNT_W-1:0] == $past(frame_count_r)
		&& reg_rdata[DATA_W-1:COUNT_W] == '0))
		else $error("Frame count read wrong");

	a_slow_reserved: assert property (@(posedge mclk) disable iff (reset)
		(!reset && reg_read && reg_addr == OFS_SLOW_CUTOFF) |=>
		(reg_rdata[DATA_W-1:SLOW_W] == '0))
		else $error("Slow threshold reserved bits set");

	a_compound_zero: assert property (@(posedge mclk) disable iff (reset)
		(!reset && reg_read && reg_addr == OFS_HUB_DESC_FIRST) |=> !reg_rdata[DT_BIT])
		else $error("Compound flag read nonzero");

	c_reload: cover property (@(posedge mclk) disable iff (timer_clr) reload);
	c_periodic: cover property (@(posedge mclk) disable iff (timer_clr) $rose(periodic_begin_r));
	c_interval_write: cover property (@(posedge mclk) disable iff (timer_clr)
		wr_hit(OFS_FRAME_INTERVAL) ##[1:20] reload);
	c_soft_keep: cover property (@(posedge mclk) disable iff (reset)
		soft_reset ##1 (power_good_delay_r != RST_POWER_GOOD));
	c_slow_closed: cover property (@(posedge mclk) disable iff (timer_clr)
		$fell(slow_packet_ok));
endmodule
`default_nettype wire

// [verification/uft_tick_source.sv]
// Purpose: Bit time source standing in for the USB line timing side
// Assumes: One tick per enabled mclk cycle
// Notes: Registered, so a tick lags enable by one cycle
`timescale 1ns/100ps
`default_nettype none
module uft_tick_source (
	input wire logic mclk,
	input wire logic reset,
	input wire logic enable,
	output logic bit_time_tick
);
	always_ff @(posedge mclk) begin
		if (reset) begin
			bit_time_tick <= 1'b0;
		end else begin
			bit_time_tick <= enable;
		end
	end
endmodule
`default_nettype wire

// [verification/uft_tb.sv]
// Purpose: Self-checking bench for frame timer and hub descriptor block
// Assumes: First controller instance; settings changed only under reset
// Notes: Interval shortened by a register write so frames after the first reload stay brief
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
	import uft_pkg::*;
	logic mclk = 0, reset = 1, soft_reset = 0, tick_en = 0, reg_write = 0, reg_read = 0;
	logic [2:0] port_setting = 3'h5;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
	logic bit_time_tick, frame_start, periodic_begin, slow_packet_ok;
	logic [13:0] time_left_counter;
	logic [15:0] frame_count_value;
	int n_errors = 0, checked = 0, cyc = 0;
	always #4 mclk = ~mclk;
	uft_tick_source u_src (.mclk(mclk), .reset(reset), .enable(tick_en), .bit_time_tick(bit_time_tick));
	uft_frame_timer u_dut (.mclk(mclk), .reset(reset), .soft_reset(soft_reset),
		.bit_time_tick(bit_time_tick), .port_setting(port_setting), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.frame_start(frame_start), .periodic_begin(periodic_begin),
		.slow_packet_ok(slow_packet_ok), .time_left_counter(time_left_counter),
		.frame_count_value(frame_count_value));
	task automatic final_report();
		if (n_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic hw_reset(input logic [2:0] s);
		@(posedge mclk);
		reset <= 1'b1;
		port_setting <= s;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic t_reset_values();
		rd(OFS_FRAME_TIME_LEFT); `CHK(rv, 32'h00002edf)
		`CHK(time_left_counter, 14'h2edf)
		`CHK(slow_packet_ok, 1'b1)
		`CHK(periodic_begin, 1'b0)
		rd(OFS_FRAME_COUNT); `CHK(rv, 32'h0)
		rd(OFS_PERIODIC_BEGIN); `CHK(rv, 32'h0)
		rd(OFS_SLOW_CUTOFF); `CHK(rv, 32'h00000628)
		rd(OFS_HUB_DESC_FIRST); `CHK(rv, 32'h0f000903)
		rd(OFS_HUB_DESC_SECOND); `CHK(rv, 32'h000e0000)
		rd(8'h50); `CHK(rv, 32'h0)
	endtask
	task automatic t_settings();
		logic [7:0] cnt[4] = '{8'h3, 8'h2, 8'h2, 8'h1};
		logic [3:0] msk[4] = '{4'he, 4'h6, 4'h6, 4'h2};
		for (int i = 0; i < 4; i++) begin
			hw_reset(3'(5 - i));
			rd(OFS_HUB_DESC_FIRST); `CHK(rv[7:0], cnt[i])
			rd(OFS_HUB_DESC_SECOND); `CHK(rv[19:16], msk[i])
		end
		hw_reset(3'h5);
	endtask
	task automatic t_write_fields();
		for (int i = 0; i < 6; i++) wr(8'h38 + 8'(4 * i), 32'hffffffff);
		rd(OFS_FRAME_TIME_LEFT); `CHK(rv, 32'h00002edf)
		rd(OFS_FRAME_COUNT); `CHK(rv, 32'h0)
		rd(OFS_PERIODIC_BEGIN); `CHK(rv, 32'h00003fff)
		rd(OFS_SLOW_CUTOFF); `CHK(rv, 32'h00000fff)
		rd(OFS_HUB_DESC_FIRST); `CHK(rv, 32'hff001b03)
		rd(OFS_HUB_DESC_SECOND); `CHK(rv, 32'h000e000e)
	endtask
	task automatic t_soft_reset();
		@(posedge mclk);
		soft_reset <= 1'b1;
		@(posedge mclk);
		soft_reset <= 1'b0;
		rd(OFS_HUB_DESC_FIRST); `CHK(rv, 32'hff001b03)
		rd(OFS_HUB_DESC_SECOND); `CHK(rv, 32'h000e000e)
		rd(OFS_PERIODIC_BEGIN); `CHK(rv, 32'h0)
		rd(OFS_SLOW_CUTOFF); `CHK(rv, 32'h00000628)
	endtask
	task automatic wait_frame();
		int n = 0;
		while (frame_start !== 1'b1 && n < 13000) begin
			@(posedge mclk);
			#1 n++;
		end
		`CHK(frame_start, 1'b1)
	endtask
	task automatic t_frames();
		wr(OFS_HUB_DESC_SECOND, 32'h0);
		wr(OFS_FRAME_INTERVAL, 32'h00000005);
		wr(OFS_PERIODIC_BEGIN, 32'h00000003);
		tick_en <= 1'b1;
		wait_frame();
		`CHK(frame_count_value, 16'h0001)
		@(posedge mclk);
		#1 wait_frame();
		`CHK(frame_count_value, 16'h0002)
		repeat (3) @(posedge mclk);
		tick_en <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 `CHK(periodic_begin, 1'b1)
		`CHK(slow_packet_ok, 1'b0)
		rd(OFS_FRAME_TIME_LEFT);
		`CHK(rv[31:14], 18'h20000)
		`CHK(rv[13:0] <= 14'h5, 1'b1)
		rd(OFS_FRAME_COUNT); `CHK(rv, 32'h00000002)
	endtask
	initial begin
		hw_reset(3'h5);
		t_reset_values();
		t_settings();
		t_write_fields();
		t_soft_reset();
		t_frames();
		final_report();
	end
endmodule
`default_nettype wire
